// ### rtl/led_diag_pkg.sv
/*
 * Constants shared by the LED fault diagnostics block: timing, register map,
 * field positions and reset values.
 * Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
 */
package led_diag_pkg;

    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned FAULT_PULSE_NS    = 50_000;
    localparam int unsigned FAULT_PULSE_CYC   = (FAULT_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned WDOG_UNIT_CYC     = 25_000;
    localparam int unsigned SYNC_STAGES       = 3;

    localparam logic [7:0] REG_CTRL_OFS       = 8'h00;
    localparam logic [7:0] REG_STATUS_OFS     = 8'h04;
    localparam logic [7:0] REG_OPEN_OFS       = 8'h08;
    localparam logic [7:0] REG_SHORT_OFS      = 8'h0C;
    localparam logic [7:0] REG_ONDEMAND_OFS   = 8'h10;
    localparam logic [7:0] REG_TIMING_OFS     = 8'h14;
    localparam logic [7:0] REG_MASK_OFS       = 8'h18;

    localparam int unsigned CTRL_CLEAR_BIT    = 0;
    localparam int unsigned CTRL_INVSTART_BIT = 1;
    localparam int unsigned CTRL_WDOG_LSB     = 4;
    localparam int unsigned CTRL_ENABLE_LSB   = 16;

    localparam int unsigned ST_PRETHERM_BIT   = 0;
    localparam int unsigned ST_TSD_BIT        = 1;
    localparam int unsigned ST_OUTFLAG_BIT    = 2;
    localparam int unsigned ST_ERRFLAG_BIT    = 3;
    localparam int unsigned ST_READY_BIT      = 4;
    localparam int unsigned ST_FAILSAFE_BIT   = 5;
    localparam int unsigned ST_FSSTATE_BIT    = 6;
    localparam int unsigned ST_TSDACT_BIT     = 7;

    localparam int unsigned TIM_DELAY_LSB     = 0;
    localparam int unsigned TIM_OPENDEG_LSB   = 8;
    localparam int unsigned TIM_SHORTDEG_LSB  = 16;
    localparam int unsigned TIM_PULSEW_LSB    = 24;

    localparam logic [3:0] WDOG_NV_DEFAULT    = 4'hF;
    localparam logic [7:0] PULSE_DELAY_RST    = 8'h10;
    localparam logic [7:0] OPEN_DEG_RST       = 8'h08;
    localparam logic [7:0] SHORT_DEG_RST      = 8'h08;
    localparam logic [7:0] PULSE_WIDTH_RST    = 8'h40;

endpackage

// ### rtl/level_sync.sv
/*
 * Three-stage synchroniser for one asynchronous level.
 * Assumes the input is quasi-static; the output changes once stages two
 * and three agree.
 */
`timescale 1ns/1ps
module level_sync (
    input  wire logic clk,     // System clock.
    input  wire logic reset_n, // Asynchronous reset, active low.
    input  wire logic din,     // Asynchronous level.
    output logic      dout     // Filtered synchronous level.
);
    logic s1Q;
    logic s2Q;
    logic s3Q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1Q  <= 1'b0;
            s2Q  <= 1'b0;
            s3Q  <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            if (s2Q == s3Q) begin
                dout <= s3Q;
            end
        end
    end
endmodule

// ### rtl/channel_monitor.sv
/*
 * Per-channel open and short deglitch counters for one LED output.
 * Assumes synchronised comparator levels and an on-phase indication;
 * counts restart whenever the on-phase ends or the condition goes away.
 */
`timescale 1ns/1ps
module channel_monitor (
    input  wire logic       clk,        // System clock.
    input  wire logic       reset_n,    // Asynchronous reset, active low.
    input  wire logic       onPhase,    // Channel drive is on.
    input  wire logic       lowHead,    // Headroom below open threshold.
    input  wire logic       lowOut,     // Output below short threshold.
    input  wire logic       supplyOk,   // Supply above low-supply threshold.
    input  wire logic [8:0] openLimit,  // Delay plus open deglitch.
    input  wire logic [8:0] shortLimit, // Delay plus short deglitch.
    output logic            openHit,    // Open qualified this cycle.
    output logic            shortHit    // Short qualified this cycle.
);
    logic [8:0] openCntQ;
    logic [8:0] shortCntQ;

    wire openRun  = onPhase && lowHead && supplyOk;
    wire shortRun = onPhase && lowOut;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            openCntQ  <= 9'h000;
            shortCntQ <= 9'h000;
        end else begin
            openCntQ  <= !openRun ? 9'h000 : (openCntQ > openLimit) ? openCntQ : openCntQ + 9'h001;
            shortCntQ <= !shortRun ? 9'h000 : (shortCntQ > shortLimit) ? shortCntQ : shortCntQ + 9'h001;
        end
    end

    assign openHit  = openRun && (openCntQ == openLimit);
    assign shortHit = shortRun && (shortCntQ == shortLimit);
endmodule

// ### rtl/led_fault_diagnostics.sv
/*
 * LED driver fault monitoring and diagnostic sequencing with APB registers.
 * Assumes asynchronous comparator levels from the analog front end and a
 * transaction-good pulse from the serial interface on the same clock.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
// Behaviour
// - Pre-thermal: pulse fault pin, set flag
// - Shutdown: drivers off, pin held, flags set
// - Cooled: outputs resume, flag stays latched
// - Extreme heat restarts from power-on defaults; there is no extreme-heat input, only reset_n restores the defaults
// - Watchdog restarts only on good addressed transaction
// - Overflow enters fail-safe state chosen by input
// - Timeout zero disables, all ones immediate
// - Open check only during long enough on-phase
// - Qualified open pulses pin, sets flags
// - Low supply suppresses open detection entirely
// - Low output sets short and error flags
// - Short needs delay plus deglitch, pulses pin
// - Short flags latched until host clears
// - Invisible start bit self-clears next cycle
// - Ready clears at start, sets at end
// - Faulty channel sets on-demand result flag
// - Diagnostic drives on-demand current, pulse width
// - Diagnostic end reports opens and shorts
// - Fault-clear clears flags and self-clears
// - Masks block reporting, detection keeps running
`timescale 1ns/1ps
module led_fault_diagnostics #(
    parameter int unsigned CHANNELS      = 12,
    parameter int unsigned WDOG_UNIT_CYC = led_diag_pkg::WDOG_UNIT_CYC
) (
    input  wire logic                clk,           // System clock, 25 MHz.
    input  wire logic                reset_n,       // Power-on reset, active low.
    input  wire logic                psel,          // APB select.
    input  wire logic                penable,       // APB enable.
    input  wire logic                pwrite,        // APB write.
    input  wire logic [7:0]          paddr,         // APB byte address.
    input  wire logic [31:0]         pwdata,        // APB write data.
    output logic                     pready,        // APB ready.
    output logic [31:0]              prdata,        // APB read data.
    output logic                     pslverr,       // APB error.
    input  wire logic                preThermIn,    // Above pre-thermal level.
    input  wire logic                thermShutIn,   // Above shutdown level.
    input  wire logic                supplyOkIn,    // Supply above low threshold.
    input  wire logic                failsafe_select_in, // Fail-safe choice.
    input  wire logic [CHANNELS-1:0] pwmOnIn,       // Channel PWM on-phase.
    input  wire logic [CHANNELS-1:0] lowHeadIn,     // Headroom below open level.
    input  wire logic [CHANNELS-1:0] lowOutIn,      // Output below short level.
    input  wire logic                txnGood,       // Good addressed transaction.
    output logic [CHANNELS-1:0]      driveEn,       // Output driver enables.
    output logic [CHANNELS-1:0]      diagCurrentSel,// Use on-demand current.
    output logic                     failsafeActive,// Fail-safe entered.
    output logic                     failsafeState, // Selected fail-safe state.
    output logic                     faultPinOut,   // Fault pin drive value.
    output logic                     faultPinOe     // Fault pin pulldown active.
);
    typedef enum {DIAG_IDLE, DIAG_PULSE, DIAG_DONE} diag_state_e;

    logic                preThermS;
    logic                thermShutS;
    logic                supplyOkS;
    logic [CHANNELS-1:0] pwmOnS;
    logic [CHANNELS-1:0] lowHeadS;
    logic [CHANNELS-1:0] lowOutS;
    logic [CHANNELS-1:0] openHit;
    logic [CHANNELS-1:0] shortHit;
    logic [CHANNELS-1:0] onPhase;

    logic [CHANNELS-1:0] channel_enable_bit_q;
    logic [3:0]          watchdog_timeout_cfg_q;
    logic [7:0]          delayQ;
    logic [7:0]          openDegQ;
    logic [7:0]          shortDegQ;
    logic [7:0]          diag_pulse_width_cfg_q;
    logic [2:0]          maskQ;
    logic                invisible_diag_start_q;
    logic                fault_clear_bit_q;

    logic                prethermal_flag_q;
    logic                thermal_shutdown_flag_q;
    logic                outFlagQ;
    logic                errFlagQ;
    logic                ondemand_ready_flag_q;
    logic [CHANNELS-1:0] channel_open_flag_q;
    logic [CHANNELS-1:0] channel_short_flag_q;
    logic [CHANNELS-1:0] ondemand_channel_flag_q;

    logic                preThermDlyQ;
    logic                tsdActiveQ;
    logic [15:0]         pulseCntQ;
    logic [19:0]         wdPrescQ;
    logic [3:0]          wdCntQ;
    diag_state_e         diagStateQ;
    logic [7:0]          diagCntQ;
    logic [CHANNELS-1:0] diagOpenQ;
    logic [CHANNELS-1:0] diagShortQ;

    level_sync syncPreTherm (.clk(clk), .reset_n(reset_n), .din(preThermIn), .dout(preThermS));
    level_sync syncTherm (.clk(clk), .reset_n(reset_n), .din(thermShutIn), .dout(thermShutS));
    level_sync syncSupply (.clk(clk), .reset_n(reset_n), .din(supplyOkIn), .dout(supplyOkS));

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_ch
            level_sync syncPwm (.clk(clk), .reset_n(reset_n), .din(pwmOnIn[g]),
                .dout(pwmOnS[g]));
            level_sync syncHead (.clk(clk), .reset_n(reset_n), .din(lowHeadIn[g]),
                .dout(lowHeadS[g]));
            level_sync syncOut (.clk(clk), .reset_n(reset_n), .din(lowOutIn[g]),
                .dout(lowOutS[g]));
            channel_monitor mon (
                .clk       (clk),
                .reset_n   (reset_n),
                .onPhase   (onPhase[g]),
                .lowHead   (lowHeadS[g]),
                .lowOut    (lowOutS[g]),
                .supplyOk  (supplyOkS),
                .openLimit ({1'b0, delayQ} + {1'b0, openDegQ}),
                .shortLimit({1'b0, delayQ} + {1'b0, shortDegQ}),
                .openHit   (openHit[g]),
                .shortHit  (shortHit[g])
            );
        end
    endgenerate

    // APB decode; the slave answers in the access cycle with no wait states.
    wire apbAccess = psel && penable;
    wire apbWrite  = apbAccess && pwrite;
    wire apbRead   = apbAccess && !pwrite;
    wire hitCtrl   = paddr == led_diag_pkg::REG_CTRL_OFS;
    wire hitStatus = paddr == led_diag_pkg::REG_STATUS_OFS;
    wire hitOpen   = paddr == led_diag_pkg::REG_OPEN_OFS;
    wire hitShort  = paddr == led_diag_pkg::REG_SHORT_OFS;
    wire hitOnDem  = paddr == led_diag_pkg::REG_ONDEMAND_OFS;
    wire hitTiming = paddr == led_diag_pkg::REG_TIMING_OFS;
    wire hitMask   = paddr == led_diag_pkg::REG_MASK_OFS;
    wire hitAny    = hitCtrl | hitStatus | hitOpen | hitShort | hitOnDem | hitTiming | hitMask;
    wire wrCtrl    = apbWrite && hitCtrl;

    wire startReq  = wrCtrl && pwdata[led_diag_pkg::CTRL_INVSTART_BIT];
    wire clearReq  = fault_clear_bit_q;
    wire diagBusy  = diagStateQ == DIAG_PULSE;
    wire diagEnd   = diagBusy && (diagCntQ == diag_pulse_width_cfg_q);

    assign onPhase = diagBusy ? {CHANNELS{1'b1}} : (pwmOnS & channel_enable_bit_q);

    // Masks gate only reporting, counters above keep running.
    wire maskOpen  = maskQ[0];
    wire maskShort = maskQ[1];
    wire maskTsd   = maskQ[2];
    wire [CHANNELS-1:0] normOpen  = diagBusy ? '0 : openHit;
    wire [CHANNELS-1:0] normShort = diagBusy ? '0 : shortHit;
    wire [CHANNELS-1:0] diagOpenFound  = diagOpenQ | openHit;
    wire [CHANNELS-1:0] diagShortFound = diagShortQ | shortHit;
    wire [CHANNELS-1:0] newOpen  = maskOpen ? '0 :
        (normOpen | (diagEnd ? diagOpenFound : '0));
    wire [CHANNELS-1:0] newShort = maskShort ? '0 :
        (normShort | (diagEnd ? diagShortFound : '0));
    wire preThermRise = preThermS && !preThermDlyQ;
    wire outEvent     = |(newOpen | newShort);
    wire tsdReport    = tsdActiveQ && !maskTsd;
    wire pulseReq     = preThermRise || outEvent;

    wire wdEnabled = watchdog_timeout_cfg_q != 4'h0;
    wire wdTick    = wdPrescQ == 20'(WDOG_UNIT_CYC - 1);
    wire wdExpire  = wdEnabled && (watchdog_timeout_cfg_q == 4'hF || (wdTick && wdCntQ ==
        watchdog_timeout_cfg_q - 4'h1));

    wire [31:0] ctrlRd   = {{(16-CHANNELS){1'b0}}, channel_enable_bit_q, 8'h00,
        watchdog_timeout_cfg_q, 2'b00, invisible_diag_start_q, fault_clear_bit_q};
    wire [31:0] statusRd = {24'h000000, tsdActiveQ, failsafeState, failsafeActive,
        ondemand_ready_flag_q, errFlagQ, outFlagQ, thermal_shutdown_flag_q, prethermal_flag_q};
    wire [31:0] readMux  = hitCtrl   ? ctrlRd :
                           hitStatus ? statusRd :
                           hitOpen   ? {{(32-CHANNELS){1'b0}}, channel_open_flag_q} :
                           hitShort  ? {{(32-CHANNELS){1'b0}}, channel_short_flag_q} :
                           hitOnDem  ? {{(32-CHANNELS){1'b0}}, ondemand_channel_flag_q} :
                           hitTiming ? {diag_pulse_width_cfg_q, shortDegQ, openDegQ, delayQ} :
                           hitMask   ? {29'h00000000, maskQ} : 32'h00000000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? readMux : prdata;
            pslverr <= psel && !penable && !hitAny;
        end
    end

    // Configuration writes; reset restores defaults, which covers power-on restart.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_enable_bit_q   <= '0;
            watchdog_timeout_cfg_q <= led_diag_pkg::WDOG_NV_DEFAULT;
            delayQ                 <= led_diag_pkg::PULSE_DELAY_RST;
            openDegQ               <= led_diag_pkg::OPEN_DEG_RST;
            shortDegQ              <= led_diag_pkg::SHORT_DEG_RST;
            diag_pulse_width_cfg_q <= led_diag_pkg::PULSE_WIDTH_RST;
            maskQ                  <= 3'h0;
        end else if (apbWrite && pready) begin
            if (hitCtrl) begin
                channel_enable_bit_q   <= pwdata[led_diag_pkg::CTRL_ENABLE_LSB +: CHANNELS];
                watchdog_timeout_cfg_q <= pwdata[led_diag_pkg::CTRL_WDOG_LSB +: 4];
            end
            if (hitTiming) begin
                delayQ                 <= pwdata[led_diag_pkg::TIM_DELAY_LSB +: 8];
                openDegQ               <= pwdata[led_diag_pkg::TIM_OPENDEG_LSB +: 8];
                shortDegQ              <= pwdata[led_diag_pkg::TIM_SHORTDEG_LSB +: 8];
                diag_pulse_width_cfg_q <= pwdata[led_diag_pkg::TIM_PULSEW_LSB +: 8];
            end
            if (hitMask) begin
                maskQ <= pwdata[2:0];
            end
        end
    end

    // Command bits self-clear one cycle after being written.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            invisible_diag_start_q <= 1'b0;
            fault_clear_bit_q      <= 1'b0;
        end else begin
            invisible_diag_start_q <= wrCtrl && pready && pwdata[led_diag_pkg::CTRL_INVSTART_BIT];
            fault_clear_bit_q      <= wrCtrl && pready && pwdata[led_diag_pkg::CTRL_CLEAR_BIT];
        end
    end

    // Latched flags; a new event in the clear cycle wins over the clear.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prethermal_flag_q       <= 1'b0;
            thermal_shutdown_flag_q <= 1'b0;
            outFlagQ                <= 1'b0;
            errFlagQ                <= 1'b0;
            channel_open_flag_q     <= '0;
            channel_short_flag_q    <= '0;
            preThermDlyQ            <= 1'b0;
            tsdActiveQ              <= 1'b0;
        end else begin
            preThermDlyQ            <= preThermS;
            tsdActiveQ              <= thermShutS;
            prethermal_flag_q       <= preThermRise || (prethermal_flag_q && !clearReq);
            thermal_shutdown_flag_q <= tsdReport || (thermal_shutdown_flag_q && !clearReq);
            channel_open_flag_q     <= newOpen | (clearReq ? '0 : channel_open_flag_q);
            channel_short_flag_q    <= newShort | (clearReq ? '0 : channel_short_flag_q);
            outFlagQ                <= outEvent || (outFlagQ && !clearReq);
            errFlagQ                <= outEvent || tsdReport || (errFlagQ && !clearReq);
        end
    end

    // Fault pin: 50 us pulse stretcher ORed with the shutdown hold.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCntQ   <= 16'h0000;
            faultPinOe  <= 1'b0;
            faultPinOut <= 1'b0;
        end else begin
            pulseCntQ   <= pulseReq ? 16'(led_diag_pkg::FAULT_PULSE_CYC) :
                (pulseCntQ != 16'h0000) ? pulseCntQ - 16'h0001 : 16'h0000;
            faultPinOe  <= pulseReq || (pulseCntQ > 16'h0001) || tsdReport;
            faultPinOut <= 1'b0;
        end
    end

    // Communication watchdog.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdPrescQ       <= 20'h00000;
            wdCntQ         <= 4'h0;
            failsafeActive <= 1'b0;
            failsafeState  <= 1'b0;
        end else begin
            if (txnGood || !wdEnabled) begin
                wdPrescQ <= 20'h00000;
                wdCntQ   <= 4'h0;
            end else if (wdTick) begin
                wdPrescQ <= 20'h00000;
                wdCntQ   <= (wdCntQ == 4'hF) ? wdCntQ : wdCntQ + 4'h1;
            end else begin
                wdPrescQ <= wdPrescQ + 20'h00001;
            end
            if (wdExpire && !failsafeActive) begin
                failsafeActive <= 1'b1;
                failsafeState  <= failsafe_select_in;
            end
        end
    end

    // Invisible diagnostic sequencer: one pulse on all channels, then report.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diagStateQ              <= DIAG_IDLE;
            diagCntQ                <= 8'h00;
            diagOpenQ               <= '0;
            diagShortQ              <= '0;
            ondemand_ready_flag_q   <= 1'b1;
            ondemand_channel_flag_q <= '0;
        end else begin
            case (diagStateQ)
                DIAG_IDLE: begin
                    if (invisible_diag_start_q) begin
                        diagStateQ              <= DIAG_PULSE;
                        diagCntQ                <= 8'h00;
                        diagOpenQ               <= '0;
                        diagShortQ              <= '0;
                        ondemand_ready_flag_q   <= 1'b0;
                        ondemand_channel_flag_q <= '0;
                    end
                end
                DIAG_PULSE: begin
                    diagCntQ   <= diagCntQ + 8'h01;
                    diagOpenQ  <= diagOpenFound;
                    diagShortQ <= diagShortFound;
                    if (diagEnd) begin
                        diagStateQ              <= DIAG_DONE;
                        ondemand_channel_flag_q <= diagOpenFound | diagShortFound;
                    end
                end
                DIAG_DONE: begin
                    diagStateQ            <= DIAG_IDLE;
                    ondemand_ready_flag_q <= 1'b1;
                end
                default: diagStateQ <= DIAG_IDLE;
            endcase
        end
    end

    // Output drivers: shutdown overrides, diagnostics force on with diag current.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            driveEn        <= '0;
            diagCurrentSel <= '0;
        end else begin
            driveEn        <= thermShutS ? '0 : diagBusy ? {CHANNELS{1'b1}} :
                channel_enable_bit_q;
            diagCurrentSel <= diagBusy ? {CHANNELS{1'b1}} : '0;
        end
    end

    wire unusedStart = startReq;
endmodule

// ### verification/led_diag_checker.sv
/* Port-level assertions for the LED fault block.
   Assumes a bind into the design. */
`timescale 1ns/1ps
module led_diag_checker #(
    parameter int unsigned CHANNELS = 12
) (
    input wire logic                clk,                // Clock.
    input wire logic                reset_n,            // Reset, active low.
    input wire logic                psel,               // Select.
    input wire logic                penable,            // Enable.
    input wire logic                pready,             // Ready.
    input wire logic                pslverr,            // Error.
    input wire logic                thermShutIn,        // Shutdown level.
    input wire logic                failsafe_select_in, // Fail-safe choice.
    input wire logic [CHANNELS-1:0] driveEn,            // Driver enables.
    input wire logic                failsafeActive,     // Fail-safe entered.
    input wire logic                failsafeState,      // Fail-safe state.
    input wire logic                faultPinOut,        // Pin value.
    input wire logic                faultPinOe          // Pin pulldown.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_tsd_drive_off: assert property (thermShutIn [*8] |-> driveEn == '0)
        else $error("drivers on during shutdown");
    a_tsd_pin_held: assert property (thermShutIn [*8] |-> faultPinOe)
        else $error("pin released in shutdown");
    a_pin_min_len: assert property ($rose(faultPinOe) |-> faultPinOe [*8])
        else $error("fault pulse too short");
    a_pin_drive_low: assert property (faultPinOe |-> !faultPinOut)
        else $error("fault pin driven high");
    a_fs_state: assert property ($rose(failsafeActive) |-> failsafeState == failsafe_select_in)
        else $error("wrong fail-safe state");
    a_fs_latch: assert property (failsafeActive |=> failsafeActive)
        else $error("fail-safe left");
    a_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property ($rose(faultPinOe));
    cover property ($rose(failsafeActive));
    cover property (pslverr);
endmodule
bind led_fault_diagnostics led_diag_checker #(.CHANNELS(CHANNELS)) u_chk (.clk, .reset_n,
    .psel, .penable, .pready, .pslverr, .thermShutIn, .failsafe_select_in, .driveEn,
    .failsafeActive, .failsafeState, .faultPinOut, .faultPinOe);

// ### verification/host_model.sv
/* Host model: APB master with one transfer task.
   Assumes a slave on the same clock. */
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk,     // Clock.
    output logic             psel,    // Select.
    output logic             penable, // Enable.
    output logic             pwrite,  // Direction.
    output logic [7:0]       paddr,   // Byte address.
    output logic [31:0]      pwdata,  // Write data.
    input  wire logic        pready,  // Ready.
    input  wire logic [31:0] prdata,  // Read data.
    input  wire logic        pslverr  // Error.
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, logic [7:0] a, logic [31:0] wd,
        output logic [31:0] rd, logic er);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule

// ### verification/tb_top.sv
/* Self-checking bench for the LED fault block.
   Assumes the APB host model. */
`timescale 1ns/1ps
module tb_top;
    logic        clk, reset_n, preThermIn, thermShutIn, supplyOkIn, fsIn, txnGood, err;
    logic        psel, penable, pwrite, pready, pslverr, fsAct, fsSt, pinOut, pinOe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [11:0] pwmOnIn, lowHeadIn, lowOutIn, driveEn, diagSel;
    int          fails, num_checks, cyc;
    host_model u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr);
    led_fault_diagnostics #(.CHANNELS(12), .WDOG_UNIT_CYC(10)) u_dut (.clk, .reset_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .preThermIn,
        .thermShutIn, .supplyOkIn, .failsafe_select_in(fsIn), .pwmOnIn, .lowHeadIn,
        .lowOutIn, .txnGood, .driveEn, .diagCurrentSel(diagSel), .failsafeActive(fsAct),
        .failsafeState(fsSt), .faultPinOut(pinOut), .faultPinOe(pinOe));
    localparam logic [7:0] CTRL = led_diag_pkg::REG_CTRL_OFS, OPEN = led_diag_pkg::REG_OPEN_OFS;
    localparam logic [7:0] STAT = led_diag_pkg::REG_STATUS_OFS, SHRT = led_diag_pkg::REG_SHORT_OFS;
    localparam logic [7:0] ODEM = led_diag_pkg::REG_ONDEMAND_OFS;
    task automatic chk(input string nm, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp, m);
        u_host.xfer(1'b0, a, 32'h0, rdat, err);
        chk(nm, exp, rdat & m);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rdat, err);
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic t_failsafe();
        rc("status", STAT, 32'h70, '1);
        chk("fsState", 1, fsSt);
        u_host.xfer(1'b0, 8'h1C, 32'h0, rdat, err);
        chk("unmapped", 32'h1, {rdat[30:0], err});
    endtask
    task automatic t_pretherm();
        preThermIn <= 1'b1;
        w(10);
        chk("pin", 1, pinOe);
        preThermIn <= 1'b0;
        rc("pretherm", STAT, 1, 32'h1);
        w(1300);
        chk("pin end", 0, pinOe);
        wr(CTRL, 32'h1);
        rc("cleared", STAT, 0, 32'h1);
        rc("clr bit", CTRL, 0, 32'h1);
    endtask
    task automatic t_open();
        wr(CTRL, 32'h0001_0000);
        {supplyOkIn, pwmOnIn[0], lowHeadIn[0]} <= 3'b011;
        w(100);
        rc("open lowsup", OPEN, 0, '1);
        supplyOkIn <= 1'b1;
        w(100);
        chk("open pin", 1, pinOe);
        rc("open", OPEN, 1, '1);
        rc("out err", STAT, 32'hC, 32'hC);
        {pwmOnIn[0], lowHeadIn[0]} <= 2'b00;
        wr(CTRL, 32'h1);
        rc("open clr", OPEN, 0, '1);
    endtask
    task automatic t_diag();
        wr(CTRL, 32'h0);
        lowOutIn[2] <= 1'b1;
        wr(CTRL, 32'h2);
        rc("busy", STAT, 0, 32'h10);
        chk("diag cur", 12'hFFF, diagSel);
        rc("start bit", CTRL, 0, 32'h2);
        w(100);
        rc("ready", STAT, 32'h10, 32'h10);
        rc("od flags", ODEM, 32'h4, '1);
        rc("short", SHRT, 32'h4, '1);
        lowOutIn[2] <= 1'b0;
        wr(CTRL, 32'h2);
        w(100);
        rc("rerun", ODEM, 0, '1);
        wr(CTRL, 32'h1);
        rc("short clr", SHRT, 0, '1);
    endtask
    task automatic t_thermal();
        wr(CTRL, 32'h0001_0000);
        pwmOnIn[0] <= 1'b1;
        w(10);
        chk("drive", 12'h001, driveEn);
        thermShutIn <= 1'b1;
        w(10);
        chk("drive off", 0, driveEn);
        chk("pin held", 1, pinOe);
        thermShutIn <= 1'b0;
        w(10);
        chk("drive on", 12'h001, driveEn);
        rc("tsd flag", STAT, 32'h2, 32'h2);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        {reset_n, preThermIn, thermShutIn, txnGood, pwmOnIn, lowHeadIn, lowOutIn} = '0;
        {supplyOkIn, fsIn} = 2'b11;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_failsafe();
        t_pretherm();
        t_open();
        t_diag();
        t_thermal();
        conclude();
    end
endmodule
